// file: dv/testbench.sv
// bench: both ends on one link, a second dram end on a faulty link
`timescale 1ns/1ps
module testbench;
  logic         sys_clk;
  logic         rstn;
  logic [3:0]   reg_addr;
  logic [31:0]  reg_wdata;
  logic         reg_wr;
  logic         reg_rd;
  logic [31:0]  reg_rdata;
  logic [1:0]   width_mode;
  logic [1:0]   f_width;
  logic         dm_en;
  logic         dbi_en;
  logic         f_dm;
  logic         commit_stb;
  logic         f_commit;
  logic [127:0] commit_data;
  logic [127:0] cm_d;
  logic [15:0]  commit_keep;
  logic [15:0]  cm_k;
  logic         precharge_stb;
  logic         f_pre;
  logic [1:0]   crc_err;
  logic [1:0]   f_err;
  logic [1:0]   fe_v;
  logic         lk_d;
  logic [15:0]  bt [16];
  int           nb, cm_n, pc_n, er_n, fc_n, fp_n, fe_n, al_n;
  int           n_fail, n_compared;

  wcc_link_if lnk ();
  wcc_link_if flnk ();

  wcc_ctrl_end wcc_ctrl_end_i (.sys_clk(sys_clk), .rstn(rstn), .link(lnk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  wcc_dram_end wcc_dram_end_i (.sys_clk(sys_clk), .rstn(rstn), .link(lnk),
    .width_mode(width_mode), .dm_en(dm_en), .dbi_en(dbi_en), .crc_en(1'b1),
    .commit_stb(commit_stb), .commit_data(commit_data), .commit_keep(commit_keep),
    .precharge_stb(precharge_stb), .crc_err(crc_err));
  wcc_dram_end wcc_dram_end_i2 (.sys_clk(sys_clk), .rstn(rstn), .link(flnk),
    .width_mode(f_width), .dm_en(f_dm), .dbi_en(1'b0), .crc_en(1'b1), .commit_stb(f_commit),
    .commit_data(), .commit_keep(), .precharge_stb(f_pre), .crc_err(f_err));
  wcc_link_asserts wcc_link_asserts_i (.sys_clk(sys_clk), .rstn(rstn), .lclk(lnk.lclk),
    .frame(lnk.frame), .apc(lnk.apc), .col_lo(lnk.col_lo), .dq(lnk.dq), .side_n(lnk.side_n),
    .alert_o(lnk.alert_o), .alert_oe(lnk.alert_oe), .alert_n(lnk.alert_n));

  // clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // reference checksum, bit 71 first, zero start
  function automatic logic [7:0] ref_crc(input logic [71:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 71; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction : ref_crc

  // expected link beat for a width, data and side bits
  function automatic logic [15:0] beat(input logic [1:0] w, input logic [127:0] d,
                                       input logic [15:0] s, input int b);
    logic [7:0]  c0;
    logic [7:0]  c1;
    logic [15:0] v;
    c0 = (w == 2'h0) ? ref_crc({40'hff_ffff_ffff, d[31:0]}) : ref_crc({s[7:0], d[63:0]});
    c1 = ref_crc({s[15:8], d[127:64]});
    v = 16'hffff;
    for (int l = 0; l < 16; l++) if (b < 8) v[l] = d[l*8+b];
    if (b == 8) v = (w == 2'h0) ? {12'hfff, c0[3:0]} : {c1, c0};
    if (b == 9 && w == 2'h0) v[3:0] = c0[7:4];
    return v;
  endfunction : beat

  task automatic chk(input string n, input logic [127:0] e, input logic [127:0] s);
    n_compared++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    d = reg_rdata;
  endtask : rd

  // beat capture on the first link, output counters on both links
  always @(posedge sys_clk) begin
    lk_d <= lnk.lclk;
    if (lnk.lclk && !lk_d && lnk.frame && nb < 16) begin
      bt[nb] = lnk.dq;
      nb++;
    end
    if (commit_stb !== 1'b0) begin
      cm_n++;
      cm_d = commit_data;
      cm_k = commit_keep;
    end
    if (precharge_stb !== 1'b0) pc_n++;
    if (crc_err !== 2'b00) er_n++;
    if (f_commit !== 1'b0) fc_n++;
    if (f_pre !== 1'b0) fp_n++;
    if (f_err !== 2'b00) begin
      fe_n++;
      fe_v = fe_v | f_err;
    end
    if (flnk.alert_n !== 1'b1) al_n++;
  end

  task automatic t_regs();
    logic [31:0] r;
    rd(wcc_pkg::REG_STATUS, r);
    chk("status reset", 128'h0, 128'(r));
    rd(wcc_pkg::REG_CTRL, r);
    chk("ctrl reset", 128'h40, 128'(r));
    wr(4'hf, 32'hffff_ffff);
    rd(4'hf, r);
    chk("unmapped", 128'h0, 128'(r));
    $display("done regs");
  endtask : t_regs

  task automatic burst(input string n, input logic [1:0] w, input logic dm, input logic dbi,
                       input logic apc, input logic [127:0] d, input logic [15:0] m);
    logic [31:0]  r;
    logic [15:0]  s;
    logic [15:0]  lm;
    logic [15:0]  km;
    logic [127:0] ed;
    logic [127:0] dmk;
    for (int k = 0; k < 50; k++) begin
      rd(wcc_pkg::REG_STATUS, r);
      if (r[0] === 1'b0) break;
    end
    width_mode <= w;
    dm_en <= dm;
    dbi_en <= dbi;
    for (int i = 0; i < 4; i++) wr(wcc_pkg::REG_DATA0 + 4'(i), d[i*32+:32]);
    wr(wcc_pkg::REG_MASK, {16'h0000, m});
    nb = 0;
    cm_n = 0;
    pc_n = 0;
    er_n = 0;
    wr(wcc_pkg::REG_CTRL, {25'h0, 1'b1, dbi, dm, w, apc, 1'b1});
    for (int k = 0; k < 300 && nb < 10; k++) @(posedge sys_clk);
    repeat (20) @(posedge sys_clk);
    s = (dm | dbi) ? m : 16'hffff;
    lm = (w == 2'h0) ? 16'h000f : (w == 2'h1 ? 16'h00ff : 16'hffff);
    km = (w == 2'h2) ? 16'hffff : 16'h00ff;
    ed = d;
    for (int l = 0; l < 16; l++) begin
      dmk[l*8+:8] = {8{lm[l]}};
      for (int b = 0; b < 8; b++) if (dbi && !m[(l/8)*8+b]) ed[l*8+b] = !d[l*8+b];
    end
    chk({n, " beats"}, 128'h0a, 128'(nb));
    for (int b = 0; b < 10; b++) chk({n, " beat"}, 128'(beat(w, d, s, b) & lm), 128'(bt[b] & lm));
    chk({n, " commits"}, 128'h1, 128'(cm_n));
    chk({n, " data"}, ed & dmk, cm_d & dmk);
    chk({n, " keep"}, 128'((dm ? m : 16'hffff) & km), 128'(cm_k & km));
    chk({n, " precharge"}, 128'(apc), 128'(pc_n));
    chk({n, " no error"}, 128'h0, 128'(er_n));
    $display("done %s", n);
  endtask : burst

  task automatic t_conflict();
    logic [31:0] r;
    nb = 0;
    repeat (40) @(posedge sys_clk);
    wr(wcc_pkg::REG_CTRL, 32'h0000_0071);
    repeat (100) @(posedge sys_clk);
    rd(wcc_pkg::REG_STATUS, r);
    chk("conflict", 128'h1, 128'(r[1]));
    chk("no burst", 128'h0, 128'(nb));
    wr(wcc_pkg::REG_STATUS, 32'h0000_0002);
    rd(wcc_pkg::REG_STATUS, r);
    chk("conflict clear", 128'h0, 128'(r[1]));
    $display("done conflict");
  endtask : t_conflict

  task automatic t_fault(input string n, input logic [1:0] w, input logic dm, input logic apc,
                         input logic [15:0] bad, input logic [1:0] ee, input int ec);
    logic [127:0] d;
    d = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;
    f_width <= w;
    f_dm <= dm;
    flnk.apc <= apc;
    fc_n = 0;
    fp_n = 0;
    fe_n = 0;
    al_n = 0;
    fe_v = 2'b00;
    @(posedge sys_clk);
    // beats sent with a corrupted checksum
    for (int b = 0; b < 10; b++) begin
      flnk.dq <= beat(w, d, 16'hffff, b) ^ (b == 8 ? bad : 16'h0000);
      flnk.frame <= 1'b1;
      #62.5 flnk.lclk <= 1'b1;
      #62.5 flnk.lclk <= 1'b0;
    end
    flnk.frame <= 1'b0;
    flnk.dq <= ~flnk.dq;
    repeat (100) @(posedge sys_clk);
    chk({n, " tree"}, 128'(ee), 128'(fe_v));
    chk({n, " errors"}, 128'h1, 128'(fe_n));
    chk({n, " alert"}, 128'(wcc_pkg::ALERT_CYC), 128'(al_n));
    chk({n, " commits"}, 128'(ec), 128'(fc_n));
    chk({n, " precharge"}, 128'(apc), 128'(fp_n));
    $display("done %s", n);
  endtask : t_fault

  task automatic final_report();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  // watchdog: the whole sequence needs under ten microseconds
  initial begin
    #200000;
    n_fail++;
    final_report();
  end

  // reset, then the scenarios in order
  initial begin
    {rstn, reg_wr, reg_rd, dm_en, dbi_en, f_dm, lk_d} = 7'h00;
    {reg_addr, reg_wdata, width_mode, f_width} = 40'h0;
    {nb, cm_n, pc_n, er_n, fc_n, fp_n, fe_n, al_n, n_fail, n_compared} = '0;
    {flnk.lclk, flnk.frame, flnk.apc, flnk.col_lo} = 6'h00;
    flnk.dq = 16'hffff;
    flnk.side_n = 2'b11;
    fe_v = 2'b00;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    t_regs();
    burst("x4", 2'h0, 1'b0, 1'b0, 1'b0, 128'hfedc_ba98_7654_3210_0f1e_2d3c_a5c3_9e71, 16'hffff);
    burst("x8 dm", 2'h1, 1'b1, 1'b0, 1'b1, 128'h1357_9bdf_0246_8ace_8421_c3a5_ff00_5a96, 16'h005a);
    burst("x16 dbi", 2'h2, 1'b0, 1'b1, 1'b0, 128'h0f0f_33cc_5555_aaaa_1234_5678_9abc_def0, 16'h3cc3);
    t_conflict();
    t_fault("x16 upper", 2'h2, 1'b1, 1'b1, 16'h0100, 2'b10, 0);
    t_fault("x8 early", 2'h1, 1'b0, 1'b0, 16'h0001, 2'b01, 1);
    final_report();
  end
endmodule : testbench

// file: dv/wcc_link_asserts.sv
// concurrent checks on the link between the two write crc ends
`timescale 1ns/1ps
module wcc_link_asserts (
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic        lclk,
  input wire logic        frame,
  input wire logic        apc,
  input wire logic [2:0]  col_lo,
  input wire logic [15:0] dq,
  input wire logic [1:0]  side_n,
  input wire logic        alert_o,
  input wire logic        alert_oe,
  input wire logic        alert_n
);
  logic       lclk_q;
  logic [3:0] beat_q;
  logic [7:0] frm_q;
  logic [7:0] idle_q;
  wire        beat_w = lclk && !lclk_q && frame;

  // beat index, frame length and idle gap counters
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      lclk_q <= 1'b0;
      beat_q <= 4'h0;
      frm_q  <= 8'h00;
      idle_q <= 8'h00;
    end else begin
      lclk_q <= lclk;
      beat_q <= !frame ? 4'h0 : (beat_w ? beat_q + 4'h1 : beat_q);
      frm_q  <= frame ? frm_q + 8'h01 : 8'h00;
      idle_q <= frame ? 8'h00 : (idle_q == 8'hff ? idle_q : idle_q + 8'h01);
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_col_zero: assert property (frame |-> col_lo == 3'h0)
    else $error("column low bits not zero in burst");
  a_no_alert: assert property (!alert_oe && alert_n)
    else $error("alert on a link with good checksums");
  a_alert_low: assert property (alert_oe |-> !alert_o)
    else $error("alert driven high");
  a_link_duty: assert property ($rose(lclk) |-> lclk [*4] ##1 !lclk)
    else $error("link clock high time wrong");
  a_beat_count: assert property ($fell(frame) |-> beat_q == 4'ha)
    else $error("burst not ten beats");
  a_frame_len: assert property ($fell(frame) |-> frm_q == 8'h50)
    else $error("frame length wrong");
  a_side_ones: assert property (beat_w && beat_q >= 4'h8 |-> side_n == 2'b11)
    else $error("mask lines not high in checksum beats");
  a_beat9_ones: assert property (beat_w && beat_q == 4'h9 |-> dq[15:4] == 12'hfff)
    else $error("last beat not ones");
  a_idle_gap: assert property ($rose(frame) |-> idle_q >= 8'h20)
    else $error("bursts too close");
  a_apc_hold: assert property (frame && $past(frame) |-> $stable(apc))
    else $error("precharge flag moved in burst");
  a_dq_setup: assert property (beat_w |-> $past(dq, 3) == dq)
    else $error("data moved before beat sample");

  c_burst: cover property ($fell(frame));
  c_masked: cover property (beat_w && side_n != 2'b11);
  c_apc: cover property ($rose(frame) && apc);
endmodule : wcc_link_asserts

// file: rtl/wcc_ctrl_end.sv
// controller end: register port, crc generation, burst framing
`timescale 1ns/1ps
module wcc_ctrl_end (
  input  wire logic          sys_clk,
  input  wire logic          rstn,
  wcc_link_if.ctrl           link,
  input  wire logic [3:0]    reg_addr,
  input  wire logic [31:0]   reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic [31:0]        reg_rdata
);

  typedef enum logic [1:0] {WCC_IDLE, WCC_SEND, WCC_GAP} wcc_state_e;

  wcc_state_e   state_q;
  logic [2:0]   div_q;
  logic [6:0]   ctrl_q;
  logic [31:0]  data_q [0:3];
  logic [15:0]  mask_q;
  logic         pend_q;
  logic         conflict_q;
  logic         alert_q;
  logic [7:0]   alert_cnt_q;
  logic [2:0]   async_q;
  logic [3:0]   beat_q;
  logic [2:0]   gap_q;
  logic [7:0]   crc0_q;
  logic [7:0]   crc1_q;
  logic         frame_q;
  logic [15:0]  dq_q;
  logic [1:0]   side_q;
  logic [31:0]  rdata_q;

  wire          fall    = (div_q == 3'h7);
  wire [127:0]  data    = {data_q[3], data_q[2], data_q[1], data_q[0]};
  wire wcc_pkg::wcc_width_e wid = wcc_pkg::wcc_width_e'(ctrl_q[wcc_pkg::CTRL_WID +: 2]);
  wire          side_en = ctrl_q[wcc_pkg::CTRL_DM] | ctrl_q[wcc_pkg::CTRL_DBI];
  wire [3:0]    last    = ctrl_q[wcc_pkg::CTRL_CRC] ? wcc_pkg::LAST_CRC_BEAT
                                                    : wcc_pkg::LAST_DATA_BEAT;
  wire          go_wr   = reg_wr & (reg_addr == wcc_pkg::REG_CTRL) &
                          reg_wdata[wcc_pkg::CTRL_GO] & (state_q == WCC_IDLE) & ~pend_q;
  wire          both_on = reg_wdata[wcc_pkg::CTRL_DM] & reg_wdata[wcc_pkg::CTRL_DBI];
  wire          st_wr   = reg_wr & (reg_addr == wcc_pkg::REG_STATUS);
  wire          alert_f = async_q[2] & ~async_q[1];

  // checksums of the pending burst
  wire [7:0] crc0 = wcc_pkg::crc8_72(wcc_pkg::code_word(data, mask_q, 1'b0, wid, side_en));
  wire [7:0] crc1 = wcc_pkg::crc8_72(wcc_pkg::code_word(data, mask_q, 1'b1, wid, side_en));

  // lane levels for the beat about to go out
  logic [15:0] nxt_dq;
  logic [1:0]  nxt_side;
  always_comb begin
    nxt_dq   = 16'hffff;
    nxt_side = 2'b11;
    if (beat_q <= wcc_pkg::LAST_DATA_BEAT) begin
      for (int l = 0; l < 16; l++) begin
        nxt_dq[l] = data[l*8 + int'(beat_q[2:0])];
      end
      if (side_en) begin
        nxt_side = {mask_q[8 + int'(beat_q[2:0])], mask_q[int'(beat_q[2:0])]};
      end
    end else if (beat_q == wcc_pkg::CRC_LO_BEAT) begin
      nxt_dq = (wid == wcc_pkg::WCC_X4) ? {12'hfff, crc0_q[3:0]} : {crc1_q, crc0_q};
    end else if (wid == wcc_pkg::WCC_X4) begin
      nxt_dq = {12'hfff, crc0_q[7:4]};
    end
  end

  // register writes; status flags set wins over clear
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q      <= wcc_pkg::CTRL_RST;
      mask_q      <= 16'hffff;
      pend_q      <= 1'b0;
      conflict_q  <= 1'b0;
      alert_q     <= 1'b0;
      alert_cnt_q <= 8'h00;
      for (int i = 0; i < 4; i++) begin
        data_q[i] <= 32'h0000_0000;
      end
    end else begin
      if (reg_wr && reg_addr == wcc_pkg::REG_CTRL && state_q == WCC_IDLE && !pend_q) begin
        ctrl_q <= {reg_wdata[6:1], 1'b0};
      end
      if (reg_wr && reg_addr >= wcc_pkg::REG_DATA0 && reg_addr < wcc_pkg::REG_MASK) begin
        data_q[2'(reg_addr - wcc_pkg::REG_DATA0)] <= reg_wdata;
      end
      if (reg_wr && reg_addr == wcc_pkg::REG_MASK) begin
        mask_q <= reg_wdata[15:0];
      end
      if (go_wr && both_on) begin
        conflict_q <= 1'b1;
      end else if (st_wr && reg_wdata[wcc_pkg::ST_CONFLICT]) begin
        conflict_q <= 1'b0;
      end
      if (alert_f) begin
        alert_q     <= 1'b1;
        alert_cnt_q <= alert_cnt_q + 8'h01;
      end else if (st_wr && reg_wdata[wcc_pkg::ST_ALERT]) begin
        alert_q <= 1'b0;
      end
      if (go_wr && !both_on) begin
        pend_q <= 1'b1;
      end else if (fall && state_q == WCC_IDLE) begin
        pend_q <= 1'b0;
      end
    end
  end

  // link clock divider and alert synchroniser
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      div_q   <= 3'h0;
      async_q <= 3'b111;
    end else begin
      div_q   <= div_q + 3'h1;
      async_q <= {async_q[1:0], link.alert_n};
    end
  end

  // burst framing; beats change on link clock fall
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= WCC_IDLE;
      beat_q  <= 4'h0;
      gap_q   <= 3'h0;
      crc0_q  <= 8'h00;
      crc1_q  <= 8'h00;
      frame_q <= 1'b0;
      dq_q    <= 16'hffff;
      side_q  <= 2'b11;
    end else if (fall) begin
      case (state_q)
        WCC_IDLE: begin
          if (pend_q) begin
            crc0_q  <= crc0;
            crc1_q  <= crc1;
            beat_q  <= 4'h0;
            state_q <= WCC_SEND;
          end
        end
        WCC_SEND: begin
          frame_q <= 1'b1;
          dq_q    <= nxt_dq;
          side_q  <= nxt_side;
          beat_q  <= beat_q + 4'h1;
          if (beat_q == last) begin
            gap_q   <= wcc_pkg::GAP_BEATS;
            state_q <= WCC_GAP;
          end
        end
        default: begin
          // idle gap keeps bursts far apart
          frame_q <= 1'b0;
          dq_q    <= 16'hffff;
          side_q  <= 2'b11;
          gap_q   <= gap_q - 3'h1;
          if (gap_q == 3'h0) begin
            state_q <= WCC_IDLE;
          end
        end
      endcase
    end
  end

  // read data one cycle after the strobe
  wire [31:0] status = {16'h0000, alert_cnt_q, 5'h00, alert_q, conflict_q,
                        (state_q != WCC_IDLE) | pend_q};
  wire [31:0] rd_mux = (reg_addr == wcc_pkg::REG_CTRL)   ? {25'h0, ctrl_q} :
                       (reg_addr == wcc_pkg::REG_MASK)   ? {16'h0, mask_q} :
                       (reg_addr == wcc_pkg::REG_STATUS) ? status :
                       (reg_addr >= wcc_pkg::REG_DATA0 && reg_addr < wcc_pkg::REG_MASK) ?
                       data_q[2'(reg_addr - wcc_pkg::REG_DATA0)] : 32'h0000_0000;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  assign link.col_lo = 3'b000;
  assign link.apc    = ctrl_q[wcc_pkg::CTRL_APC];
  assign link.lclk   = div_q[2];
  assign link.frame  = frame_q;
  assign link.dq     = dq_q;
  assign link.side_n = side_q;
  assign reg_rdata   = rdata_q;

endmodule : wcc_ctrl_end

// file: rtl/wcc_dram_end.sv
// dram end: write burst capture, crc check, commit and alert
//
// Summary of operation
// - recompute crc, compare, flag mismatch
// - controller builds crc and beat frames
// - x4: 32 data bits, upper 40 ones
// - x8: 64 data, upper 8 mask/ones
// - x16: two independent trees, one per byte
// - x8/x16: controller sends ones in last beat; x4 last beat carries crc bits 7:4
// - mismatch pulls alert low
// - dm off: commit early, controller repairs
// - dm and crc: check first, block bad
// - auto precharge happens despite crc error
// - crc on raw bits, invert for array
// - controller never enables write dbi with dm
// - 1-clock preamble: no 4-clock column spacing
// - 2-clock preamble: no 6-clock column spacing
// - no mpr writes, no per-device mode
// - crc8 polynomial x^8+x^2+x+1
// - zero start, bit 71 first
// - eight parallel xor trees
// - fixed burst order, low column zero
`timescale 1ns/1ps
module wcc_dram_end (
  input  wire logic          sys_clk,
  input  wire logic          rstn,
  wcc_link_if.dram           link,
  input  wire logic [1:0]    width_mode,
  input  wire logic          dm_en,
  input  wire logic          dbi_en,
  input  wire logic          crc_en,
  output logic               commit_stb,
  output logic [127:0]       commit_data,
  output logic [15:0]        commit_keep,
  output logic               precharge_stb,
  output logic [1:0]         crc_err
);

  typedef enum logic [1:0] {WCC_IDLE, WCC_RECV, WCC_EVAL} wcc_state_e;

  localparam int unsigned SYNC_W = 21;

  wcc_state_e        state_q;
  wcc_state_e        state_d;
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic              lclk_q;
  logic [17:0]       beat_q [0:9];
  logic [3:0]        cnt_q;
  logic              apc_q;
  logic              data_done_q;
  logic [7:0]        alert_cnt_q;
  logic              alert_oe_q;
  logic              commit_q;
  logic [127:0]      commit_data_q;
  logic [15:0]       commit_keep_q;
  logic              precharge_q;
  logic [1:0]        crc_err_q;

  wire               s_lclk  = sync2_q[20];
  wire               s_frame = sync2_q[19];
  wire               s_apc   = sync2_q[18];
  wire [17:0]        s_bus   = sync2_q[17:0];
  wire               rise    = s_lclk & ~lclk_q;
  wire               take    = rise & s_frame & (state_q != WCC_EVAL);
  wire [3:0]         last    = crc_en ? wcc_pkg::LAST_CRC_BEAT : wcc_pkg::LAST_DATA_BEAT;
  wire wcc_pkg::wcc_width_e wid = wcc_pkg::wcc_width_e'(width_mode);

  // link inputs cross into sys_clk through two flops
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sync1_q <= '0;
      sync2_q <= '0;
      lclk_q  <= 1'b0;
    end else begin
      sync1_q <= {link.lclk, link.frame, link.apc, link.side_n, link.dq};
      sync2_q <= sync1_q;
      lclk_q  <= s_lclk;
    end
  end

  // beats stored strictly in arrival order
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 10; i++) begin
        beat_q[i] <= '1;
      end
    end else if (take) begin
      beat_q[cnt_q] <= s_bus;
    end
  end

  // reassemble lane-major data and mask/inversion bits
  logic [127:0] rx_data;
  logic [15:0]  rx_side;
  logic [127:0] wr_data;
  logic [15:0]  wr_keep;

  genvar ln;
  genvar bt;
  generate
    for (ln = 0; ln < 16; ln++) begin : g_lane
      for (bt = 0; bt < 8; bt++) begin : g_beat
        assign rx_data[ln*8+bt] = beat_q[bt][ln];
        // inversion undone only for array data
        assign wr_data[ln*8+bt] = beat_q[bt][ln] ^ (dbi_en & ~beat_q[bt][16+ln/8]);
      end
    end
    for (bt = 0; bt < 8; bt++) begin : g_side
      assign rx_side[bt]   = beat_q[bt][16];
      assign rx_side[8+bt] = beat_q[bt][17];
      assign wr_keep[bt]   = dm_en ? beat_q[bt][16] : 1'b1;
      assign wr_keep[8+bt] = (wid == wcc_pkg::WCC_X16) & (dm_en ? beat_q[bt][17] : 1'b1);
    end
  endgenerate

  // received checksum per byte group
  wire [7:0] rx_crc0 = (wid == wcc_pkg::WCC_X4) ? {beat_q[9][3:0], beat_q[8][3:0]}
                                                : beat_q[8][7:0];
  wire [7:0] rx_crc1 = beat_q[8][15:8];

  // x4 word pads upper 40 with ones
  // x8 upper byte: mask/dbi bits or ones
  wire [71:0] word0 = wcc_pkg::code_word(rx_data, rx_side, 1'b0, wid, dm_en | dbi_en);
  wire [71:0] word1 = wcc_pkg::code_word(rx_data, rx_side, 1'b1, wid, dm_en | dbi_en);

  // second independent tree for upper byte
  wire [7:0] calc0 = wcc_pkg::crc8_72(word0);
  wire [7:0] calc1 = wcc_pkg::crc8_72(word1);

  wire [1:0] err_now = {(wid == wcc_pkg::WCC_X16) & (calc1 != rx_crc1), calc0 != rx_crc0};
  wire       eval    = (state_q == WCC_EVAL);
  wire       late    = dm_en & crc_en;

  // early commit when masking is off
  wire       commit_now = late ? (eval & ~|err_now) : data_done_q;

  // precharge at burst end regardless of error
  wire       end_now = crc_en ? eval : data_done_q;

  // burst sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      WCC_IDLE: begin
        if (take) begin
          state_d = WCC_RECV;
        end
      end
      WCC_RECV: begin
        if (rise & ~s_frame) begin
          state_d = WCC_IDLE;
        end else if (take && cnt_q == last) begin
          state_d = crc_en ? WCC_EVAL : WCC_IDLE;
        end
      end
      default: begin
        state_d = WCC_IDLE;
      end
    endcase
  end

  // beat counter and burst attributes
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_q     <= WCC_IDLE;
      cnt_q       <= 4'h0;
      apc_q       <= 1'b0;
      data_done_q <= 1'b0;
    end else begin
      state_q     <= state_d;
      data_done_q <= take & (cnt_q == wcc_pkg::LAST_DATA_BEAT);
      if (state_d == WCC_IDLE || state_d == WCC_EVAL) begin
        cnt_q <= 4'h0;
      end else if (take) begin
        cnt_q <= cnt_q + 4'h1;
      end
      if (take && cnt_q == 4'h0) begin
        apc_q <= s_apc;
      end
    end
  end

  // single evaluation and error pulse per burst
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      crc_err_q   <= 2'b00;
      commit_q    <= 1'b0;
      precharge_q <= 1'b0;
    end else begin
      crc_err_q   <= eval ? err_now : 2'b00;
      commit_q    <= commit_now;
      precharge_q <= end_now & apc_q;
    end
  end

  // committed word held until next commit
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      commit_data_q <= '0;
      commit_keep_q <= '0;
    end else if (commit_now) begin
      commit_data_q <= wr_data;
      commit_keep_q <= wr_keep;
    end
  end

  // alert held low for a fixed pulse
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      alert_cnt_q <= 8'h00;
      alert_oe_q  <= 1'b0;
    end else begin
      if (eval && err_now != 2'b00) begin
        alert_cnt_q <= 8'(wcc_pkg::ALERT_CYC);
        alert_oe_q  <= 1'b1;
      end else if (alert_cnt_q != 8'h00) begin
        alert_cnt_q <= alert_cnt_q - 8'h01;
        alert_oe_q  <= (alert_cnt_q != 8'h01);
      end
    end
  end

  assign link.alert_o   = 1'b0;
  assign link.alert_oe  = alert_oe_q;
  assign commit_stb     = commit_q;
  assign commit_data    = commit_data_q;
  assign commit_keep    = commit_keep_q;
  assign precharge_stb  = precharge_q;
  assign crc_err        = crc_err_q;

endmodule : wcc_dram_end

// file: rtl/wcc_link_if.sv
// link between write crc controller and dram end
`timescale 1ns/1ps
interface wcc_link_if;
  logic        lclk;
  logic        frame;
  logic        apc;
  logic [2:0]  col_lo;
  logic [15:0] dq;
  logic [1:0]  side_n;
  logic        alert_o;
  logic        alert_oe;
  logic        alert_n;

  // open-drain alert with pull-up
  assign alert_n = alert_oe ? alert_o : 1'b1;

  modport ctrl (output lclk, frame, apc, col_lo, dq, side_n, input alert_n);
  modport dram (input lclk, frame, apc, col_lo, dq, side_n, output alert_o, alert_oe);
endinterface : wcc_link_if

// file: rtl/wcc_pkg.sv
// shared constants, types and crc functions for the write crc link
package wcc_pkg;

  // clocking and timing
  localparam int unsigned SYS_CLK_MHZ = 125;
  localparam int unsigned LCLK_DIV    = 8;
  localparam int unsigned ALERT_NS    = 400;
  localparam int unsigned ALERT_CYC   = (ALERT_NS * SYS_CLK_MHZ + 999) / 1000;

  // burst shape, in link clock beats
  localparam logic [3:0]  LAST_DATA_BEAT = 4'h7;
  localparam logic [3:0]  LAST_CRC_BEAT  = 4'h9;
  localparam logic [3:0]  CRC_LO_BEAT    = 4'h8;
  localparam logic [2:0]  GAP_BEATS      = 3'h3;

  // checksum generator x^8 + x^2 + x + 1, all-zero start
  localparam logic [7:0]  CRC_POLY = 8'h07;
  localparam logic [7:0]  CRC_INIT = 8'h00;
  localparam logic [39:0] X4_FILL  = 40'hff_ffff_ffff;

  // controller register map (word addresses)
  localparam logic [3:0]  REG_CTRL   = 4'h0;
  localparam logic [3:0]  REG_DATA0  = 4'h1;
  localparam logic [3:0]  REG_MASK   = 4'h5;
  localparam logic [3:0]  REG_STATUS = 4'h6;

  // control register fields
  localparam int unsigned CTRL_GO  = 0;
  localparam int unsigned CTRL_APC = 1;
  localparam int unsigned CTRL_WID = 2;
  localparam int unsigned CTRL_DM  = 4;
  localparam int unsigned CTRL_DBI = 5;
  localparam int unsigned CTRL_CRC = 6;
  localparam logic [6:0]  CTRL_RST = 7'h40;

  // status register fields
  localparam int unsigned ST_BUSY     = 0;
  localparam int unsigned ST_CONFLICT = 1;
  localparam int unsigned ST_ALERT    = 2;
  localparam int unsigned ST_CNT      = 8;

  typedef enum logic [1:0] {WCC_X4, WCC_X8, WCC_X16} wcc_width_e;

  // serial crc over 72 bits, bit 71 shifted in first
  function automatic logic [7:0] crc8_72(input logic [71:0] d);
    logic [7:0] c;
    logic       fb;
    c = CRC_INIT;
    for (int i = 71; i >= 0; i--) begin
      fb = c[7] ^ d[i];
      c  = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
    end
    return c;
  endfunction : crc8_72

  // code word of one byte group; data is lane-major, bit lane*8+beat
  function automatic logic [71:0] code_word(input logic [127:0] data,
                                            input logic [15:0]  side,
                                            input logic         grp,
                                            input wcc_width_e   wid,
                                            input logic         side_en);
    if (wid == WCC_X4) begin
      return {X4_FILL, data[31:0]};
    end
    return {(side_en ? side[{grp, 3'b000} +: 8] : 8'hff), data[{grp, 6'h00} +: 64]};
  endfunction : code_word

endpackage : wcc_pkg
